//--- rtl/fpc_regs.sv
// Overview of operation
// - with blank check on, test the sector for erasure before erasing
// - blank sector under blank check: abort, no erase pulses issued
// - blank check off: every erase request is executed
// - buffer size bit: 0 gives 256 bytes, 1 gives 512; default 0
// - program data past the buffer size wraps the buffer address
// - impedance code maps to 45,120,90,60,45,30,-,15 ohms; 110 undefined
// - a changed impedance code applies at once in normal operation
// - ecc mode 0: multi-pass allowed, reprogrammed unit has ecc disabled
// - ecc mode 1 default: 1-bit correct, 2-bit detect, reprogram errors
// - ecc works on 16-byte units; reprogram checks are per unit
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module fpc_regs (
  input  wire logic                  i_clock,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_clk_en,
  input  wire logic [2:0]            i_reg_addr,
  input  wire logic [7:0]            i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  output logic      [7:0]            o_reg_rdata,
  input  wire logic                  i_erase_req,
  input  wire logic                  i_check_done,
  input  wire logic                  i_sector_blank,
  output logic                       o_check_start,
  output logic                       o_erase_start,
  output logic                       o_erase_abort,
  input  wire logic                  i_prog_begin,
  input  wire logic                  i_prog_byte,
  input  wire logic                  i_unit_programmed,
  output logic      [8:0]            o_buf_addr,
  output logic                       o_buf_wr,
  output logic                       o_buf_512,
  output logic      [6:0]            o_drive_ohms,
  output logic                       o_drive_undef,
  output logic                       o_ecc_dbl_detect_en,
  output logic                       o_unit_ecc_off,
  output logic                       o_prog_error
);

  // ----------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------
  logic [7:0]                 ep_nv_r;
  logic [7:0]                 ep_v_r;
  logic [7:0]                 de_nv_r;
  logic [7:0]                 de_v_r;
  logic                       load_pend_r;
  logic [7:0]                 rdata_r;
  logic [7:0]                 rdata_nxt;
  fpc_pkg::fpc_state_t        state_r;
  logic                       drive_undef_r;
  logic                       prog_err_seen_r;
  logic                       blank_buf_r;

  // write decode, reserved bits are never stored
  wire logic                  wr_ep_nv = i_reg_wr && (i_reg_addr == fpc_pkg::OFF_EP_NV);
  wire logic                  wr_ep_v  = i_reg_wr && (i_reg_addr == fpc_pkg::OFF_EP_V);
  wire logic                  wr_de_nv = i_reg_wr && (i_reg_addr == fpc_pkg::OFF_DE_NV);
  wire logic                  wr_de_v  = i_reg_wr && (i_reg_addr == fpc_pkg::OFF_DE_V);
  wire logic [7:0]            wd_ep    = i_reg_wdata & fpc_pkg::MASK_EP;
  wire logic [7:0]            wd_de    = i_reg_wdata & fpc_pkg::MASK_DE;

  // governing fields come from the volatile copies only
  wire logic                  blank_chk_en = ep_v_r[fpc_pkg::BIT_BLANK_CHK];
  wire logic                  buf_sel_512  = ep_v_r[fpc_pkg::BIT_BUF_SIZE];
  wire logic [2:0]            impd_sel     = de_v_r[fpc_pkg::POS_IMPD +: 3];
  wire logic                  ecc_mode     = de_v_r[fpc_pkg::BIT_ECC_MODE];

  // ----------------------------------------------------------
  // non-volatile copies
  // ----------------------------------------------------------
  // reset here stands in for the factory image of the array
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ep_nv_r <= fpc_pkg::RST_EP;
      de_nv_r <= fpc_pkg::RST_DE;
    end else if (i_clk_en) begin
      if (wr_ep_nv) ep_nv_r <= wd_ep;
      if (wr_de_nv) de_nv_r <= wd_de;
    end
  end

  // ----------------------------------------------------------
  // volatile copies
  // ----------------------------------------------------------
  // loaded from the stored copy on the first enabled edge after
  // release; a host write in that same edge wins as the newer value
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ep_v_r      <= fpc_pkg::RST_EP;
      de_v_r      <= fpc_pkg::RST_DE;
      load_pend_r <= 1'b1;
    end else if (i_clk_en) begin
      load_pend_r <= 1'b0;
      if (wr_ep_v)          ep_v_r <= wd_ep;
      else if (load_pend_r) ep_v_r <= ep_nv_r;
      if (wr_de_v)          de_v_r <= wd_de;
      else if (load_pend_r) de_v_r <= de_nv_r;
    end
  end

  // ----------------------------------------------------------
  // read port
  // ----------------------------------------------------------
  // unmapped indices read zero; data stands one cycle after strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_reg_rd) begin
      case (i_reg_addr)
        fpc_pkg::OFF_EP_NV:  rdata_nxt = ep_nv_r;
        fpc_pkg::OFF_EP_V:   rdata_nxt = ep_v_r;
        fpc_pkg::OFF_DE_NV:  rdata_nxt = de_nv_r;
        fpc_pkg::OFF_DE_V:   rdata_nxt = de_v_r;
        fpc_pkg::OFF_STATUS: rdata_nxt = {5'h00, state_r == fpc_pkg::FPC_CHECK,
                                          drive_undef_r, prog_err_seen_r};
        default:             rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) rdata_r <= 8'h00;
    else if (i_clk_en) rdata_r <= rdata_nxt;
  end

  // ----------------------------------------------------------
  // erase sequencer
  // ----------------------------------------------------------
  fpc_pkg::fpc_state_t        state_nxt;
  logic                       chk_start_r;
  logic                       chk_start_nxt;
  logic                       er_start_r;
  logic                       er_start_nxt;
  logic                       er_abort_r;
  logic                       er_abort_nxt;

  // requests arriving while a check is open are ignored
  always_comb begin
    state_nxt     = state_r;
    chk_start_nxt = 1'b0;
    er_start_nxt  = 1'b0;
    er_abort_nxt  = 1'b0;
    case (state_r)
      fpc_pkg::FPC_IDLE: begin
        if (i_erase_req && blank_chk_en) begin
          chk_start_nxt = 1'b1;
          state_nxt     = fpc_pkg::FPC_CHECK;
        end else if (i_erase_req) begin
          er_start_nxt  = 1'b1;
        end
      end
      fpc_pkg::FPC_CHECK: begin
        if (i_check_done) begin
          er_abort_nxt = i_sector_blank;
          er_start_nxt = !i_sector_blank;
          state_nxt    = fpc_pkg::FPC_IDLE;
        end
      end
      default: state_nxt = fpc_pkg::FPC_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r     <= fpc_pkg::FPC_IDLE;
      chk_start_r <= 1'b0;
      er_start_r  <= 1'b0;
      er_abort_r  <= 1'b0;
    end else if (i_clk_en) begin
      state_r     <= state_nxt;
      chk_start_r <= chk_start_nxt;
      er_start_r  <= er_start_nxt;
      er_abort_r  <= er_abort_nxt;
    end
  end

  // ----------------------------------------------------------
  // page program buffer address
  // ----------------------------------------------------------
  logic [8:0]                 buf_addr_r;
  logic                       buf_wr_r;
  logic [8:0]                 buf_addr_nxt;

  // address of the byte taken this cycle; the limit is sampled per
  // byte, so changing the size mid-page takes effect at once
  wire logic [8:0]            buf_max = buf_sel_512 ? fpc_pkg::BUF_MAX_512
                                                    : fpc_pkg::BUF_MAX_256;
  wire logic [8:0]            buf_cur = i_prog_begin ? 9'h000 : buf_addr_r;
  wire logic                  buf_wrap = (buf_cur >= buf_max);

  assign buf_addr_nxt = buf_wrap ? 9'h000 : 9'(buf_cur + 9'h001);

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      buf_addr_r <= 9'h000;
      buf_wr_r   <= 1'b0;
    end else if (i_clk_en) begin
      buf_wr_r <= i_prog_byte;
      if (i_prog_byte) buf_addr_r <= buf_addr_nxt;
      else if (i_prog_begin) buf_addr_r <= 9'h000;
    end
  end

  // last written address, shown to the array beside the write pulse
  logic [8:0]                 buf_out_r;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) buf_out_r <= 9'h000;
    else if (i_clk_en && i_prog_byte) buf_out_r <= buf_cur;
  end

  // ----------------------------------------------------------
  // ecc unit handling
  // ----------------------------------------------------------
  logic                       unit_off_r;
  logic                       prog_err_r;

  // a unit closes on its sixteenth byte; the array reports whether
  // it held data already, which makes this a second pass
  wire logic                  unit_close = i_prog_byte &&
                                           (buf_cur[3:0] == fpc_pkg::UNIT_LAST_BYTE);
  wire logic                  reprog     = unit_close && i_unit_programmed;

  // error history is sticky until the mode register is rewritten;
  // a new error in that same edge keeps the flag set
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unit_off_r      <= 1'b0;
      prog_err_r      <= 1'b0;
      prog_err_seen_r <= 1'b0;
    end else if (i_clk_en) begin
      unit_off_r <= reprog && !ecc_mode;
      prog_err_r <= reprog && ecc_mode;
      if (reprog && ecc_mode) prog_err_seen_r <= 1'b1;
      else if (wr_de_v)       prog_err_seen_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // drive impedance
  // ----------------------------------------------------------
  logic [6:0]                 ohms_nxt;
  logic [6:0]                 ohms_r;
  logic                       dbl_det_r;

  always_comb begin
    case (impd_sel)
      3'h1:    ohms_nxt = fpc_pkg::OHM_120;
      3'h2:    ohms_nxt = fpc_pkg::OHM_90;
      3'h3:    ohms_nxt = fpc_pkg::OHM_60;
      3'h5:    ohms_nxt = fpc_pkg::OHM_30;
      3'h7:    ohms_nxt = fpc_pkg::OHM_15;
      3'h6:    ohms_nxt = fpc_pkg::OHM_45; // undefined code, keep safe drive
      default: ohms_nxt = fpc_pkg::OHM_45;
    endcase
  end

  // follows the volatile copy every cycle, no special mode needed
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ohms_r        <= fpc_pkg::OHM_45;
      drive_undef_r <= 1'b0;
      dbl_det_r     <= fpc_pkg::RST_DE[fpc_pkg::BIT_ECC_MODE];
    end else if (i_clk_en) begin
      ohms_r        <= ohms_nxt;
      drive_undef_r <= (impd_sel == fpc_pkg::IMPD_UNDEF);
      dbl_det_r     <= ecc_mode;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign o_reg_rdata         = rdata_r;
  assign o_check_start       = chk_start_r;
  assign o_erase_start       = er_start_r;
  assign o_erase_abort       = er_abort_r;
  assign o_buf_addr          = buf_out_r;
  assign o_buf_wr            = buf_wr_r;
  assign o_buf_512           = blank_buf_r;
  assign o_drive_ohms        = ohms_r;
  assign o_drive_undef       = drive_undef_r;
  assign o_ecc_dbl_detect_en = dbl_det_r;
  assign o_unit_ecc_off      = unit_off_r;
  assign o_prog_error        = prog_err_r;

  // registered copy of the buffer size for the array side

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) blank_buf_r <= fpc_pkg::RST_EP[fpc_pkg::BIT_BUF_SIZE];
    else if (i_clk_en) blank_buf_r <= buf_sel_512;
  end

endmodule // fpc_regs
`default_nettype wire

//--- rtl/fpc_pkg.sv
`default_nettype none
package fpc_pkg;
  // ----------------------------------------------------------
  // register map (byte index on the plain register port)
  // ----------------------------------------------------------
  localparam int          ADDR_W         = 3;
  localparam logic [2:0]  OFF_EP_NV      = 3'h0;
  localparam logic [2:0]  OFF_EP_V       = 3'h1;
  localparam logic [2:0]  OFF_DE_NV      = 3'h2;
  localparam logic [2:0]  OFF_DE_V       = 3'h3;
  localparam logic [2:0]  OFF_STATUS     = 3'h4;

  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int          BIT_BLANK_CHK  = 5;
  localparam int          BIT_BUF_SIZE   = 4;
  localparam int          POS_IMPD       = 5;
  localparam int          BIT_ECC_MODE   = 3;
  localparam logic [7:0]  MASK_EP        = 8'h30;
  localparam logic [7:0]  MASK_DE        = 8'hE8;

  // ----------------------------------------------------------
  // factory defaults
  // ----------------------------------------------------------
  localparam logic [7:0]  RST_EP         = 8'h20;
  localparam logic [7:0]  RST_DE         = 8'h08;

  // ----------------------------------------------------------
  // buffer and ecc geometry
  // ----------------------------------------------------------
  localparam int          BUF_AW         = 9;
  localparam logic [8:0]  BUF_MAX_256    = 9'h0FF;
  localparam logic [8:0]  BUF_MAX_512    = 9'h1FF;
  localparam logic [3:0]  UNIT_LAST_BYTE = 4'hF;

  // ----------------------------------------------------------
  // drive impedance codes and ohm values
  // ----------------------------------------------------------
  localparam logic [2:0]  IMPD_UNDEF     = 3'h6;
  localparam logic [6:0]  OHM_15         = 7'h0F;
  localparam logic [6:0]  OHM_30         = 7'h1E;
  localparam logic [6:0]  OHM_45         = 7'h2D;
  localparam logic [6:0]  OHM_60         = 7'h3C;
  localparam logic [6:0]  OHM_90         = 7'h5A;
  localparam logic [6:0]  OHM_120        = 7'h78;

  // erase sequencer states
  typedef enum logic [1:0] {FPC_IDLE, FPC_CHECK} fpc_state_t;
endpackage
`default_nettype wire

//--- rtl/fpc_regs_end.sv
`timescale 1ns/1ns

//--- sim/fpc_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// port checks of the configuration block
// ------------------------------------------------
module fpc_regs_checker (
  input wire logic       i_clock,
  input wire logic       i_reset_n,
  input wire logic       i_clk_en,
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_wr,
  input wire logic       i_check_done,
  input wire logic       i_sector_blank,
  input wire logic       o_check_start,
  input wire logic       o_erase_start,
  input wire logic       o_erase_abort,
  input wire logic       i_prog_begin,
  input wire logic       i_prog_byte,
  input wire logic       i_unit_programmed,
  input wire logic [8:0] o_buf_addr,
  input wire logic       o_buf_wr,
  input wire logic       o_buf_512,
  input wire logic [6:0] o_drive_ohms,
  input wire logic       o_ecc_dbl_detect_en,
  input wire logic       o_unit_ecc_off,
  input wire logic       o_prog_error
);
  // own code to ohms table, the undefined code keeps 45
  localparam logic [6:0] OHM_TAB [8] = '{fpc_pkg::OHM_45, fpc_pkg::OHM_120, fpc_pkg::OHM_90,
    fpc_pkg::OHM_60, fpc_pkg::OHM_45, fpc_pkg::OHM_30, fpc_pkg::OHM_45, fpc_pkg::OHM_15};
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  a_check_gap: assert property (o_check_start |=> !o_erase_start && !o_erase_abort)
    else $error("erase decided before blank check answer");
  a_abort_blank: assert property (i_clk_en && i_check_done && i_sector_blank
    |=> o_erase_abort && !o_erase_start) else $error("blank sector not aborted");
  a_erase_full: assert property (i_clk_en && i_check_done && !i_sector_blank
    |=> o_erase_start && !o_erase_abort) else $error("programmed sector not erased");
  a_first_byte: assert property (i_clk_en && i_prog_byte && i_prog_begin
    |=> o_buf_wr && o_buf_addr == 9'h000) else $error("page start not at address 0");
  a_addr_wrap: assert property (i_clk_en && i_prog_byte && !i_prog_begin |=> o_buf_wr &&
    o_buf_addr == (($past(o_buf_addr) + 9'h001) & ($past(o_buf_512) ? 9'h1FF : 9'h0FF)))
    else $error("buffer address step or wrap wrong");
  a_reprog_error: assert property (i_clk_en && i_prog_byte && i_unit_programmed
    |=> o_prog_error == (o_buf_addr[3:0] == 4'hF && $past(o_ecc_dbl_detect_en)))
    else $error("reprogram error pulse wrong");
  a_reprog_eccoff: assert property (i_clk_en && i_prog_byte && i_unit_programmed
    |=> o_unit_ecc_off == (o_buf_addr[3:0] == 4'hF && !$past(o_ecc_dbl_detect_en)))
    else $error("unit ecc off pulse wrong");
  a_drive_apply: assert property (i_clk_en && i_reg_wr && i_reg_addr == 3'h3 ##1 i_clk_en
    |=> o_drive_ohms == OHM_TAB[$past(i_reg_wdata[7:5], 2)] &&
    o_ecc_dbl_detect_en == $past(i_reg_wdata[3], 2)) else $error("drive or ecc not applied");
endmodule // fpc_regs_checker

bind fpc_regs fpc_regs_checker u_fpc_chk (.i_clock, .i_reset_n, .i_clk_en, .i_reg_addr,
  .i_reg_wdata, .i_reg_wr, .i_check_done, .i_sector_blank, .o_check_start, .o_erase_start,
  .o_erase_abort, .i_prog_begin, .i_prog_byte, .i_unit_programmed, .o_buf_addr, .o_buf_wr,
  .o_buf_512, .o_drive_ohms, .o_ecc_dbl_detect_en, .o_unit_ecc_off, .o_prog_error);
`default_nettype wire

//--- sim/fpc_sector_model.sv
`timescale 1ns/1ns
`default_nettype none
module fpc_sector_model (
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  input  wire logic       i_check_start,
  input  wire logic       i_blank,
  input  wire logic [3:0] i_delay,
  output logic            o_check_done,
  output logic            o_sector_blank
);
  logic       busy_r;
  logic       last_r;
  logic [3:0] cnt_r;
  // result line is only valid with done; otherwise show the inverse
  assign o_sector_blank = o_check_done ? last_r : ~last_r;
  // blank check answers after a set number of cycles, 0 being prompt
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_r <= 1'h0;
      last_r <= 1'h0;
      cnt_r <= 4'h0;
      o_check_done <= 1'h0;
    end else begin
      o_check_done <= 1'h0;
      if (i_check_start) begin
        busy_r <= 1'h1;
        cnt_r <= i_delay;
      end else if (busy_r && cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end else if (busy_r) begin
        o_check_done <= 1'h1;
        last_r <= i_blank;
        busy_r <= 1'h0;
      end
    end
  end
endmodule // fpc_sector_model
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic       i_clock = 1'h0, i_reset_n = 1'h0, i_clk_en = 1'h1, i_reg_wr = 1'h0;
  logic       i_reg_rd = 1'h0, i_erase_req = 1'h0, i_prog_begin = 1'h0, i_prog_byte = 1'h0;
  logic       i_unit_programmed = 1'h0, blank = 1'h0, i_check_done, i_sector_blank;
  logic       o_check_start, o_erase_start, o_erase_abort, o_buf_wr, o_buf_512;
  logic       o_drive_undef, o_ecc_dbl_detect_en, o_unit_ecc_off, o_prog_error;
  logic [2:0] i_reg_addr = 3'h0;
  logic [7:0] i_reg_wdata = 8'h00, o_reg_rdata;
  logic [8:0] o_buf_addr;
  logic [6:0] o_drive_ohms;
  logic [3:0] dly = 4'h0;
  int         n_errors = 0, n_checks = 0;
  localparam logic [6:0] OHM_TAB [8] = '{fpc_pkg::OHM_45, fpc_pkg::OHM_120, fpc_pkg::OHM_90,
    fpc_pkg::OHM_60, fpc_pkg::OHM_45, fpc_pkg::OHM_30, fpc_pkg::OHM_45, fpc_pkg::OHM_15};

  fpc_regs dut (.i_clock, .i_reset_n, .i_clk_en, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_erase_req, .i_check_done, .i_sector_blank, .o_check_start,
    .o_erase_start, .o_erase_abort, .i_prog_begin, .i_prog_byte, .i_unit_programmed,
    .o_buf_addr, .o_buf_wr, .o_buf_512, .o_drive_ohms, .o_drive_undef,
    .o_ecc_dbl_detect_en, .o_unit_ecc_off, .o_prog_error);
  fpc_sector_model far (.i_clock, .i_reset_n, .i_check_start(o_check_start), .i_blank(blank),
    .i_delay(dly), .o_check_done(i_check_done), .o_sector_blank(i_sector_blank));

  // 125 MHz clock
  always #4 i_clock = ~i_clock;

  // ------------------------------------------------
  // bus cycles and compare
  // ------------------------------------------------
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1'h1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_reg_rd <= 1'h1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_rd <= 1'h0;
    @(negedge i_clock);
    chk("rdata", {1'h0, e}, {1'h0, o_reg_rdata});
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic defaults();
    @(posedge i_clock);
    i_reset_n <= 1'h0;
    repeat (5) @(posedge i_clock);
    i_reset_n <= 1'h1;
    @(negedge i_clock);
    chk("drive_ohms", {2'h0, fpc_pkg::OHM_45}, {2'h0, o_drive_ohms});
    chk("ecc_mode", 9'h001, {8'h00, o_ecc_dbl_detect_en});
    chk("buf_512", 9'h000, {8'h00, o_buf_512});
    rd(fpc_pkg::OFF_EP_NV, fpc_pkg::RST_EP);
    rd(fpc_pkg::OFF_EP_V, fpc_pkg::RST_EP);
    rd(fpc_pkg::OFF_DE_NV, fpc_pkg::RST_DE);
    rd(fpc_pkg::OFF_DE_V, fpc_pkg::RST_DE);
    rd(fpc_pkg::OFF_STATUS, 8'h00);
  endtask
  task automatic erase(input logic b, input logic on);
    blank = b;
    @(posedge i_clock);
    i_erase_req <= 1'h1;
    @(posedge i_clock);
    i_erase_req <= 1'h0;
    @(negedge i_clock);
    chk("check_start", {8'h00, on}, {8'h00, o_check_start});
    chk("erase_now", {8'h00, !on}, {8'h00, o_erase_start});
    for (int k = 0; k < 20 && on && o_erase_abort !== 1'h1 && o_erase_start !== 1'h1; k++)
      @(negedge i_clock);
    chk("erase_abort", {8'h00, on & b}, {8'h00, o_erase_abort});
    chk("erase_start", {8'h00, !(on & b)}, {8'h00, o_erase_start});
  endtask
  // back-to-back bytes, one unit flagged as already holding data
  task automatic prog(input int n, input int rep, input logic [8:0] last,
                      input int perr, input int poff);
    int ne = 0;
    int no = 0;
    for (int i = 0; i <= n; i++) begin
      @(posedge i_clock);
      i_prog_byte <= (i < n);
      i_prog_begin <= (i == 0);
      i_unit_programmed <= (i == rep);
      @(negedge i_clock);
      ne += (o_prog_error === 1'h1);
      no += (o_unit_ecc_off === 1'h1);
    end
    chk("buf_addr", last, o_buf_addr);
    chk("prog_error", 9'(perr), 9'(ne));
    chk("ecc_off", 9'(poff), 9'(no));
  endtask
  task automatic drive();
    for (int c = 0; c < 8; c++) begin
      wr(fpc_pkg::OFF_DE_V, {3'(c), 5'h08});
      @(posedge i_clock);
      @(negedge i_clock);
      chk("drive_ohms", {2'h0, OHM_TAB[c]}, {2'h0, o_drive_ohms});
      chk("undef", {8'h00, c == 6}, {8'h00, o_drive_undef});
      rd(fpc_pkg::OFF_STATUS, (c == 6) ? 8'h02 : 8'h00);
    end
  endtask
  // a write while the clock enable is low must not land
  task automatic freeze();
    @(posedge i_clock);
    i_clk_en <= 1'h0;
    wr(fpc_pkg::OFF_DE_V, 8'h28);
    @(posedge i_clock);
    i_clk_en <= 1'h1;
    @(negedge i_clock);
    chk("drive_ohms", {2'h0, fpc_pkg::OHM_15}, {2'h0, o_drive_ohms});
    rd(fpc_pkg::OFF_DE_V, 8'hE8);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence, second reset in mid-run at the end
  initial begin
    defaults();
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    dly = 4'h3;
    erase(1'h1, 1'h1);
    dly = 4'h0;
    erase(1'h0, 1'h1);
    wr(fpc_pkg::OFF_EP_V, 8'h10);
    prog(514, 15, 9'h001, 1, 0);
    rd(fpc_pkg::OFF_STATUS, 8'h01);
    wr(fpc_pkg::OFF_DE_V, 8'h00);
    erase(1'h1, 1'h0);
    wr(fpc_pkg::OFF_EP_V, 8'h00);
    prog(258, 31, 9'h001, 0, 1);
    prog(20, 7, 9'h013, 0, 0);
    drive();
    freeze();
    wr(fpc_pkg::OFF_EP_NV, 8'h10);
    rd(fpc_pkg::OFF_EP_NV, 8'h10);
    defaults();
    complete_run();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    complete_run();
  end
endmodule // testbench
`default_nettype wire
